// ===== design/sfdpb_pkg.sv
/*
  Package for the basic parameter table content block: table addresses,
  field positions and encodings, and the request and answer carriers.
  Assumes a byte-wide parameter read path driven by a command decoder.
*/
package sfdpb_pkg;

  // ----------------------------------------------------------------------
  // Command and table placement
  // ----------------------------------------------------------------------
  localparam logic [7:0] read_discoverable_params_cmd = 8'h5A;
  localparam int unsigned ADDR_BYTES = 3;
  localparam logic [7:0] HDR_PTR_ADDR = 8'h0C;
  localparam logic [7:0] HDR_LEN_ADDR = 8'h0B;
  localparam logic [7:0] TBL_FIRST = 8'h30;
  localparam logic [7:0] TBL_LEN_DW = 8'h09;
  localparam logic [7:0] TBL_LAST = 8'h3B;

  // ----------------------------------------------------------------------
  // Byte 30h and 31h fields
  // ----------------------------------------------------------------------
  localparam logic [1:0] ERASE_4K_CODE = 2'h1;
  localparam logic [0:0] WR_GRAN_64B = 1'h1;
  localparam logic [0:0] VOL_WREN_REQ = 1'h0;
  localparam logic [0:0] VOL_WREN_SEL = 1'h0;
  localparam logic [2:0] B30_UNUSED = 3'h7;
  localparam logic [7:0] ERASE_4K_OPCODE = 8'h20;

  // ----------------------------------------------------------------------
  // Byte 32h fields
  // ----------------------------------------------------------------------
  localparam logic [0:0] FR_112_SUP = 1'h1;
  localparam logic [1:0] ADDR_MODE_3B = 2'h0;
  localparam logic [0:0] DTR_SUP = 1'h0;
  localparam logic [0:0] FR_122_SUP = 1'h0;
  localparam logic [0:0] FR_144_SUP = 1'h0;
  localparam logic [0:0] FR_114_SUP = 1'h0;
  localparam logic [0:0] B32_UNUSED = 1'h1;

  // ----------------------------------------------------------------------
  // Density and quad read fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] UNUSED_BYTE = 8'hFF;
  localparam logic [31:0] DENSITY_WORD = 32'h007FFFFF;
  localparam logic [4:0] NO_WAIT = 5'h00;
  localparam logic [2:0] NO_MODE = 3'h0;
  localparam logic [7:0] NO_OPCODE = 8'hFF;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic next;
    logic [23:0] addr;
  } sfdpb_req_type;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [7:0] data;
  } sfdpb_rsp_type;

endpackage

// ===== design/sfdpb_rom.sv
/*
  Basic parameter table content (bytes 30h..3Bh) with an address counter.
  Assumes the command decoder has taken opcode 5Ah, three address bytes and
  one dummy byte, pulses start with the address, and pulses next per byte
  shifted out while chip select stays low. Chip select high ends the read.
*/
`timescale 1ns/100ps

module sfdpb_rom (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire sfdpb_pkg::sfdpb_req_type req,
  output sfdpb_pkg::sfdpb_rsp_type rsp,
  output logic [7:0] hdr_ptr,
  output logic [7:0] hdr_len
);

  // ----------------------------------------------------------------------
  // Table content
  // ----------------------------------------------------------------------
  function automatic logic [7:0] tbl_byte(input logic [3:0] idx);
    logic [7:0] b;
    b = sfdpb_pkg::UNUSED_BYTE;
    unique case (idx)
      4'h0: b = {sfdpb_pkg::B30_UNUSED, sfdpb_pkg::VOL_WREN_SEL,
                 sfdpb_pkg::VOL_WREN_REQ, sfdpb_pkg::WR_GRAN_64B,
                 sfdpb_pkg::ERASE_4K_CODE};
      4'h1: b = sfdpb_pkg::ERASE_4K_OPCODE;
      4'h2: b = {sfdpb_pkg::B32_UNUSED, sfdpb_pkg::FR_114_SUP, sfdpb_pkg::FR_144_SUP,
                 sfdpb_pkg::FR_122_SUP, sfdpb_pkg::DTR_SUP,
                 sfdpb_pkg::ADDR_MODE_3B, sfdpb_pkg::FR_112_SUP};
      4'h3: b = sfdpb_pkg::UNUSED_BYTE;
      4'h4: b = sfdpb_pkg::DENSITY_WORD[7:0];
      4'h5: b = sfdpb_pkg::DENSITY_WORD[15:8];
      4'h6: b = sfdpb_pkg::DENSITY_WORD[23:16];
      4'h7: b = sfdpb_pkg::DENSITY_WORD[31:24];
      4'h8: b = {sfdpb_pkg::NO_MODE, sfdpb_pkg::NO_WAIT};
      4'h9: b = sfdpb_pkg::NO_OPCODE;
      4'hA: b = {sfdpb_pkg::NO_MODE, sfdpb_pkg::NO_WAIT};
      4'hB: b = sfdpb_pkg::NO_OPCODE;
      default: b = sfdpb_pkg::UNUSED_BYTE;
    endcase
    return b;
  endfunction

  function automatic logic in_table(input logic [23:0] a);
    return (a[23:8] == 16'h0000) && (a[7:0] >= sfdpb_pkg::TBL_FIRST)
      && (a[7:0] <= sfdpb_pkg::TBL_LAST);
  endfunction

  // ----------------------------------------------------------------------
  // Address counter and output byte
  // ----------------------------------------------------------------------
  logic [23:0] addr_q, addr_d, cur;
  logic active_q, active_d;
  sfdpb_pkg::sfdpb_rsp_type rsp_q, rsp_d;

  always_comb begin
    addr_d = addr_q;
    active_d = active_q;
    rsp_d = rsp_q;
    rsp_d.valid = 1'b0;
    cur = addr_q;
    if (cs_n) begin
      active_d = 1'b0;
    end else if (req.start || (req.next && active_q)) begin
      cur = req.start ? req.addr : addr_q;
      active_d = 1'b1;
      addr_d = cur + 24'h000001;
      rsp_d.valid = 1'b1;
      rsp_d.hit = in_table(cur);
      rsp_d.data = sfdpb_pkg::UNUSED_BYTE;
      if (in_table(cur)) begin
        rsp_d.data = tbl_byte(4'(cur[7:0] - sfdpb_pkg::TBL_FIRST));
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= 24'h000000;
      active_q <= 1'b0;
      rsp_q <= '0;
    end else if (clk_en) begin
      addr_q <= addr_d;
      active_q <= active_d;
      rsp_q <= rsp_d;
    end
  end

  assign rsp = rsp_q;
  assign hdr_ptr = sfdpb_pkg::TBL_FIRST;
  assign hdr_len = sfdpb_pkg::TBL_LEN_DW;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_byte30_value: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !cs_n && req.start && req.addr == 24'h000030) |=> rsp.data == 8'hE5)
    else $error("byte 30h not E5h");
  a_byte31_value: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !cs_n && req.start && req.addr == 24'h000031) |=> rsp.data == 8'h20)
    else $error("byte 31h not 20h");
  a_byte32_value: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !cs_n && req.start && req.addr == 24'h000032) |=> rsp.data == 8'h81)
    else $error("byte 32h not 81h");
  a_byte33_value: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !cs_n && req.start && req.addr == 24'h000033) |=> rsp.data == 8'hFF)
    else $error("byte 33h not FFh");
  a_density_low: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !cs_n && req.start && req.addr == 24'h000034) |=> rsp.data == 8'hFF)
    else $error("density low byte wrong");
  a_density_high: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !cs_n && req.start && req.addr == 24'h000037) |=> rsp.data == 8'h00)
    else $error("density high byte wrong");
  a_quad_wait: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !cs_n && req.start && (req.addr == 24'h000038 || req.addr == 24'h00003A))
    |=> rsp.data == 8'h00)
    else $error("quad wait byte not zero");
  a_quad_opcode: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !cs_n && req.start && (req.addr == 24'h000039 || req.addr == 24'h00003B))
    |=> rsp.data == 8'hFF)
    else $error("quad opcode not FFh");
  a_addr_ascend: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !cs_n && req.start) |=> addr_q == $past(req.addr) + 24'h000001)
    else $error("address did not advance");
  a_cs_ends: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && cs_n) |=> !active_q && !rsp.valid)
    else $error("read continued after deselect");
  a_header_ptr: assert property (@(posedge clk) disable iff (!rstn)
    hdr_ptr == 8'h30 && hdr_len == 8'h09)
    else $error("header pointer wrong");

  // ----------------------------------------------------------------------
  // Field checks on returned bytes 30h, 32h, 36h, 38h and 3Ah, started or stepped
  // ----------------------------------------------------------------------
  a_erase_size: assert property (@(posedge clk) disable iff (!rstn)
    (rsp.valid && addr_q == 24'h000031)
    |-> rsp.data[1:0] == 2'h1)
    else $error("erase size field wrong");

  a_write_gran: assert property (@(posedge clk) disable iff (!rstn)
    (rsp.valid && addr_q == 24'h000031)
    |-> rsp.data[2] == 1'h1)
    else $error("write granularity bit wrong");

  a_vol_wren: assert property (@(posedge clk) disable iff (!rstn)
    (rsp.valid && addr_q == 24'h000031)
    |-> rsp.data[4:3] == 2'h0)
    else $error("volatile write enable bits wrong");

  a_dual_read: assert property (@(posedge clk) disable iff (!rstn)
    (rsp.valid && addr_q == 24'h000033)
    |-> rsp.data[0] == 1'h1 && rsp.data[6:4] == 3'h0)
    else $error("fast read support bits wrong");

  a_addr_mode: assert property (@(posedge clk) disable iff (!rstn)
    (rsp.valid && addr_q == 24'h000033)
    |-> rsp.data[2:1] == 2'h0)
    else $error("address byte field wrong");

  a_dtr_flag: assert property (@(posedge clk) disable iff (!rstn)
    (rsp.valid && addr_q == 24'h000033)
    |-> rsp.data[3] == 1'h0)
    else $error("double rate flag wrong");

  a_quad_mode: assert property (@(posedge clk) disable iff (!rstn)
    (rsp.valid && (addr_q == 24'h000039 || addr_q == 24'h00003B))
    |-> rsp.data[7:5] == 3'h0)
    else $error("quad mode bits not zero");

  a_density_mid: assert property (@(posedge clk) disable iff (!rstn)
    (rsp.valid && addr_q == 24'h000037)
    |-> rsp.data == 8'h7F)
    else $error("density third byte wrong");

  // ----------------------------------------------------------------------
  // Handshake checks
  // ----------------------------------------------------------------------
  a_valid_next: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !cs_n && (req.start || (req.next && active_q)))
    |=> rsp.valid)
    else $error("taken request not answered");

  a_valid_single: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !(!cs_n && (req.start || (req.next && active_q))))
    |=> !rsp.valid)
    else $error("answer without request");

  a_orphan_next: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !cs_n && !req.start && req.next && !active_q)
    |=> !rsp.valid)
    else $error("next answered without start");

  a_next_ascend: assert property (@(posedge clk) disable iff (!rstn)
    (clk_en && !cs_n && !req.start && req.next && active_q)
    |=> addr_q == $past(addr_q) + 24'h000001)
    else $error("address did not step");

  a_clk_freeze: assert property (@(posedge clk) disable iff (!rstn)
    !clk_en
    |=> $stable(rsp) && $stable(addr_q) && $stable(active_q))
    else $error("state moved while disabled");

endmodule // sfdpb_rom

// ===== bench/sfdpb_host.sv
/*
  Host model: drives chip select and the start/next request carrier.
  Assumes opcode, address and dummy bytes are decoded upstream of the block.
*/
`timescale 1ns/100ps
module sfdpb_host (
  input wire logic clk,
  output logic cs_n,
  output sfdpb_pkg::sfdpb_req_type req
);
  initial begin
    cs_n = 1'h1;
    req = '0;
  end
  // Select and request on the next edge
  task automatic sel(input logic c, input logic s, input logic n, input logic [23:0] a);
    @(posedge clk);
    cs_n <= c;
    req <= {s, n, a};
  endtask
  // Drop start, drive next from n, scramble the released address
  task automatic step(input logic n);
    req <= {1'h0, n, ~req.addr};
  endtask
endmodule // sfdpb_host

// ===== bench/tb_top.sv
/*
  Testbench for the parameter table block: table reads, refusals, reset.
  Assumes the host model in sfdpb_host and a 100 MHz clock.
*/
`timescale 1ns/100ps
module tb_top;
  logic clk;
  logic rstn;
  logic clk_en;
  logic cs_n;
  sfdpb_pkg::sfdpb_req_type req;
  sfdpb_pkg::sfdpb_rsp_type rsp;
  logic [7:0] hdr_ptr;
  logic [7:0] hdr_len;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  sfdpb_host host (.clk(clk), .cs_n(cs_n), .req(req));
  sfdpb_rom DUT (.clk(clk), .rstn(rstn), .clk_en(clk_en), .cs_n(cs_n), .req(req),
    .rsp(rsp), .hdr_ptr(hdr_ptr), .hdr_len(hdr_len));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Checks and expected table
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [8:0] exp_at(input logic [23:0] a);
    logic [7:0] t [0:11];
    t = '{8'hE5, 8'h20, 8'h81, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF};
    if (a >= 24'h30 && a <= 24'h3B) return {1'h1, t[a - 24'h30]};
    return {1'h0, 8'hFF};
  endfunction
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic run(input logic [23:0] a, input int n);
    host.sel(1'h0, 1'h1, n > 1, a);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      host.step(i < n - 1);
      #1;
      chk("byte", exp_at(a + 24'(i)), {rsp.hit, rsp.data});
      chk("valid", 9'h1, {8'h0, rsp.valid});
    end
    host.sel(1'h1, 1'h0, 1'h0, 24'h0);
    #1;
    chk("valid end", 9'h0, {8'h0, rsp.valid});
    $display("test run %h done", a);
  endtask
  task automatic refuse(input logic c, input logic e, input logic s, input logic n);
    host.sel(c, s, n, 24'h30);
    clk_en <= e;
    repeat (2) begin
      @(posedge clk);
      host.step(1'h0);
      clk_en <= 1'h1;
      #1;
      chk("refused", 9'h0, {8'h0, rsp.valid});
    end
    host.sel(1'h1, 1'h0, 1'h0, 24'h0);
    $display("test refuse %b%b%b%b done", c, e, s, n);
  endtask
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 500) begin
      fails++;
      close_out();
    end
  end
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    rstn = 1'h0;
    clk_en = 1'h1;
    repeat (4) @(posedge clk);
    #1;
    chk("rsp reset", 9'h0, {rsp.hit, rsp.data});
    chk("hdr_ptr", 9'h30, {1'h0, hdr_ptr});
    chk("hdr_len", 9'h09, {1'h0, hdr_len});
    @(posedge clk);
    rstn <= 1'h1;
    run(24'h30, 12);
    run(24'h2F, 3);
    run(24'h3A, 3);
    refuse(1'h1, 1'h1, 1'h1, 1'h0);
    refuse(1'h0, 1'h1, 1'h0, 1'h1);
    refuse(1'h0, 1'h0, 1'h1, 1'h0);
    run(24'h34, 4);
    for (logic [23:0] a = 24'h30; a <= 24'h3B; a++) begin
      run(a, 1);
    end
    close_out();
  end
endmodule // tb_top
